// ---- core/pmrw_consts.svh ----
// constants for the power mode, reset and watchdog controller
// assumes a 25 MHz core clock
`ifndef PMRW_CONSTS_SVH
`define PMRW_CONSTS_SVH

`define PMRW_CLK_HZ          25000000
`define PMRW_WDT_WARN_MS     2000
`define PMRW_WDT_RESET_MS    4000
`define PMRW_WDT_WARN_CYC    ((`PMRW_CLK_HZ / 1000) * `PMRW_WDT_WARN_MS)
`define PMRW_WDT_RESET_CYC   ((`PMRW_CLK_HZ / 1000) * `PMRW_WDT_RESET_MS)
`define PMRW_SEQ_STEP_CYC    16
`define PMRW_CLKSEL_RST      2'h0
`define PMRW_MODE_RST        3'h0

`endif

// ---- core/pmrw_pkg.sv ----
// types for the power mode, reset and watchdog controller
// assumes the constants header is included by users
package pmrw_pkg;

   typedef enum logic [2:0] {
      PMRW_MODE_ACTIVE = 3'h0,
      PMRW_MODE_IDLE   = 3'h1,
      PMRW_MODE_SLEEP  = 3'h2,
      PMRW_MODE_PDS    = 3'h3,
      PMRW_MODE_EXTENDED_POWER_DOWN_SLEEP   = 3'h4,
      PMRW_MODE_OFF    = 3'h5
   } pmrw_mode_e;

   // gray along off -> buck -> ldo -> wait stable -> run
   typedef enum logic [2:0] {
      PMRW_ST_OFF    = 3'h0,
      PMRW_ST_BUCK   = 3'h1,
      PMRW_ST_LDO    = 3'h3,
      PMRW_ST_STABLE = 3'h2,
      PMRW_ST_RUN    = 3'h6,
      PMRW_ST_LOWPWR = 3'h7
   } pmrw_state_e;

   typedef enum logic [1:0] {
      PMRW_SRC_LOWPWR = 2'h0,
      PMRW_SRC_ACCURATE = 2'h1,
      PMRW_SRC_CRYSTAL  = 2'h2
   } pmrw_clksrc_e;

endpackage

// ---- core/pmrw_power_ctrl.sv ----
// power sequencer, low-power mode control, wake cause, watchdog, lockout
// assumes pins (external reset, brownout, gpio wake, stable flags) are asynchronous
`timescale 1ns/1ns
`include "pmrw_consts.svh"

module pmrw_power_ctrl #(
   parameter int unsigned WARN_CYC  = `PMRW_WDT_WARN_CYC,
   parameter int unsigned RESET_CYC = `PMRW_WDT_RESET_CYC,
   parameter int unsigned STEP_CYC  = `PMRW_SEQ_STEP_CYC,
   parameter int unsigned GPIO_W    = 8
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rstn,
   // pins from outside
   input  wire logic              extResetN,
   input  wire logic              brownoutLow,
   input  wire logic              ldoStable,
   input  wire logic [GPIO_W-1:0] gpioWake,
   // firmware control
   input  wire logic [1:0]        slowClkSel,
   input  wire logic              modeReqValid,
   input  wire logic [2:0]        modeReq,
   input  wire logic              cpuWfi,
   input  wire logic              wakeTimerExpired,
   input  wire logic [GPIO_W-1:0] gpioWakeEnable,
   input  wire logic              wakeCauseClear,
   input  wire logic              wdtEnable,
   input  wire logic              wdtKick,
   input  wire logic              lockoutFound,
   input  wire logic              lockoutValid,
   input  wire logic              debugEnableReq,
   input  wire logic              rawReadCmd,
   // supply and clock controls
   output logic                   buckEnable,
   output logic                   radioLdoEnable,
   output logic                   digitalLdoEnable,
   output logic                   ldoLowVoltage,
   output logic                   coreResetN,
   output logic                   shutdown,
   output logic [2:0]             slowClkSrcEn,
   output logic                   slowClkRun,
   output logic                   fastClkRun,
   output logic                   fastClkSlow,
   output logic                   periphClkGate,
   output logic                   radioPower,
   output logic                   corePower,
   output logic                   retentionPower,
   // status
   output logic [2:0]             currentMode,
   output logic                   wokeFromOff,
   output logic [GPIO_W-1:0]      wakeGpioCause,
   output logic                   wakeByTimer,
   output logic                   debugAccessEn,
   output logic                   rawReadAllow,
   output logic                   wdtWarnIrq
);

   // ********************************************
   // pin synchronisers
   // ********************************************
   localparam int unsigned SW = GPIO_W + 3;
   logic [SW-1:0] syncA_r;
   logic [SW-1:0] syncB_r;
   logic          extRstnS;
   logic          brownS;
   logic          stableS;
   logic [GPIO_W-1:0] gpioS;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         syncA_r <= {SW{1'b0}};
         syncB_r <= {SW{1'b0}};
      end else begin
         syncA_r <= {gpioWake, ldoStable, brownoutLow, extResetN};
         syncB_r <= syncA_r;
      end
   end

   assign extRstnS = syncB_r[0];
   assign brownS   = syncB_r[1];
   assign stableS  = syncB_r[2];
   assign gpioS    = syncB_r[SW-1:3];

   // ********************************************
   // watchdog
   // ********************************************
   logic wdtResetReq;

   pmrw_watchdog #(
      .WARN_CYC  (WARN_CYC),
      .RESET_CYC (RESET_CYC)
   ) u_wdt (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .wdtEnable   (wdtEnable && coreResetN),
      .wdtKick     (wdtKick),
      .wdtWarnIrq  (wdtWarnIrq),
      .wdtResetReq (wdtResetReq)
   );

   // ********************************************
   // sequencer and mode state
   // ********************************************
   pmrw_pkg::pmrw_state_e st_r;
   pmrw_pkg::pmrw_state_e st_nxt;
   logic [15:0]           step_r;
   logic [15:0]           step_nxt;
   logic [2:0]            mode_r;
   logic [2:0]            mode_nxt;
   logic [2:0]            pend_r;
   logic [2:0]            pend_nxt;
   logic                  pendV_r;
   logic                  pendV_nxt;
   logic                  offWake_r;
   logic                  offWake_nxt;
   logic [GPIO_W-1:0]     cause_r;
   logic [GPIO_W-1:0]     cause_nxt;
   logic                  causeTmr_r;
   logic                  causeTmr_nxt;
   logic                  wakeEv;
   logic [GPIO_W-1:0]     gpioHit;
   logic                  forceReset;

   assign gpioHit    = gpioS & gpioWakeEnable;
   assign wakeEv     = wakeTimerExpired || (|gpioHit);
   // brownout, external reset and watchdog reset all drop buck and regulators and restart from off
   assign forceReset = !extRstnS || brownS || wdtResetReq;

   always_comb begin
      st_nxt       = st_r;
      step_nxt     = step_r;
      mode_nxt     = mode_r;
      pend_nxt     = pend_r;
      pendV_nxt    = pendV_r;
      offWake_nxt  = offWake_r;
      cause_nxt    = cause_r;
      causeTmr_nxt = causeTmr_r;
      if (wakeCauseClear) begin
         offWake_nxt  = 1'b0;
         cause_nxt    = {GPIO_W{1'b0}};
         causeTmr_nxt = 1'b0;
      end
      if (modeReqValid) begin
         pend_nxt  = modeReq;
         pendV_nxt = 1'b1;
      end
      case (st_r)
         pmrw_pkg::PMRW_ST_OFF: begin
            step_nxt = 16'h0;
            st_nxt   = pmrw_pkg::PMRW_ST_BUCK;
         end
         pmrw_pkg::PMRW_ST_BUCK: begin
            step_nxt = step_r + 16'h1;
            if (step_r == 16'(STEP_CYC - 1)) begin
               step_nxt = 16'h0;
               st_nxt   = pmrw_pkg::PMRW_ST_LDO;
            end
         end
         pmrw_pkg::PMRW_ST_LDO: begin
            st_nxt = pmrw_pkg::PMRW_ST_STABLE;
         end
         pmrw_pkg::PMRW_ST_STABLE: begin
            if (stableS) begin
               st_nxt   = pmrw_pkg::PMRW_ST_RUN;
               mode_nxt = `PMRW_MODE_RST;
            end
         end
         pmrw_pkg::PMRW_ST_RUN: begin
            if (pendV_r && cpuWfi) begin
               pendV_nxt = modeReqValid;
               mode_nxt  = pend_r;
               if (pend_r != 3'(pmrw_pkg::PMRW_MODE_ACTIVE)) begin
                  st_nxt = pmrw_pkg::PMRW_ST_LOWPWR;
               end
            end
         end
         pmrw_pkg::PMRW_ST_LOWPWR: begin
            if (mode_r == 3'(pmrw_pkg::PMRW_MODE_IDLE) && !cpuWfi) begin
               mode_nxt = `PMRW_MODE_RST;
               st_nxt   = pmrw_pkg::PMRW_ST_RUN;
            end else if (wakeEv) begin
               mode_nxt = `PMRW_MODE_RST;
               if (mode_r == 3'(pmrw_pkg::PMRW_MODE_OFF)) begin
                  // full restart, cause kept; set beats clear
                  offWake_nxt  = 1'b1;
                  cause_nxt    = gpioHit;
                  causeTmr_nxt = wakeTimerExpired;
                  st_nxt       = pmrw_pkg::PMRW_ST_OFF;
               end else begin
                  st_nxt = pmrw_pkg::PMRW_ST_RUN;
               end
            end
         end
         default: begin
            st_nxt = pmrw_pkg::PMRW_ST_OFF;
         end
      endcase
      if (forceReset) begin
         st_nxt    = pmrw_pkg::PMRW_ST_OFF;
         mode_nxt  = `PMRW_MODE_RST;
         pendV_nxt = 1'b0;
         step_nxt  = 16'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r       <= pmrw_pkg::PMRW_ST_OFF;
         step_r     <= 16'h0;
         mode_r     <= `PMRW_MODE_RST;
         pend_r     <= `PMRW_MODE_RST;
         pendV_r    <= 1'b0;
         offWake_r  <= 1'b0;
         cause_r    <= {GPIO_W{1'b0}};
         causeTmr_r <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         step_r     <= step_nxt;
         mode_r     <= mode_nxt;
         pend_r     <= pend_nxt;
         pendV_r    <= pendV_nxt;
         offWake_r  <= offWake_nxt;
         cause_r    <= cause_nxt;
         causeTmr_r <= causeTmr_nxt;
      end
   end

   // ********************************************
   // lockout and debug gating
   // ********************************************
   logic lock_r;
   logic lock_nxt;
   logic dbg_r;
   logic dbg_nxt;

   always_comb begin
      lock_nxt = lock_r;
      dbg_nxt  = dbg_r;
      if (lockoutValid) begin
         lock_nxt = lockoutFound;
      end
      if (debugEnableReq && !lock_r && !(lockoutValid && lockoutFound)) begin
         dbg_nxt = 1'b1;
      end
      if (lock_r || (lockoutValid && lockoutFound)) begin
         dbg_nxt = 1'b0;
      end
      if (st_r != pmrw_pkg::PMRW_ST_RUN && st_r != pmrw_pkg::PMRW_ST_LOWPWR) begin
         dbg_nxt  = 1'b0;
         lock_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         lock_r <= 1'b0;
         dbg_r  <= 1'b0;
      end else begin
         lock_r <= lock_nxt;
         dbg_r  <= dbg_nxt;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   logic inLow;
   logic [2:0] effMode;

   assign inLow   = (st_r == pmrw_pkg::PMRW_ST_LOWPWR);
   assign effMode = inLow ? mode_r : 3'(pmrw_pkg::PMRW_MODE_ACTIVE);

   always_comb begin
      buckEnable       = (st_r != pmrw_pkg::PMRW_ST_OFF);
      radioLdoEnable   = buckEnable && (st_r != pmrw_pkg::PMRW_ST_BUCK);
      digitalLdoEnable = radioLdoEnable;
      coreResetN       = (st_r == pmrw_pkg::PMRW_ST_RUN) || inLow;
      fastClkRun       = 1'b1;
      fastClkSlow      = 1'b0;
      periphClkGate    = 1'b0;
      ldoLowVoltage    = 1'b0;
      radioPower       = radioLdoEnable;
      corePower        = digitalLdoEnable;
      retentionPower   = 1'b1;
      slowClkRun       = 1'b1;
      case (effMode)
         3'(pmrw_pkg::PMRW_MODE_IDLE): begin
            fastClkSlow = 1'b1;
         end
         3'(pmrw_pkg::PMRW_MODE_SLEEP): begin
            fastClkRun    = 1'b0;
            periphClkGate = 1'b1;
            ldoLowVoltage = 1'b1;
         end
         3'(pmrw_pkg::PMRW_MODE_PDS): begin
            fastClkRun    = 1'b0;
            periphClkGate = 1'b1;
            radioPower    = 1'b0;
            corePower     = 1'b0;
         end
         3'(pmrw_pkg::PMRW_MODE_EXTENDED_POWER_DOWN_SLEEP): begin
            fastClkRun     = 1'b0;
            periphClkGate  = 1'b1;
            radioPower     = 1'b0;
            corePower      = 1'b0;
            ldoLowVoltage  = 1'b1;
         end
         3'(pmrw_pkg::PMRW_MODE_OFF): begin
            fastClkRun     = 1'b0;
            periphClkGate  = 1'b1;
            radioPower     = 1'b0;
            corePower      = 1'b0;
            retentionPower = 1'b0;
            slowClkRun     = 1'b0;
            buckEnable       = 1'b0;
            radioLdoEnable   = 1'b0;
            digitalLdoEnable = 1'b0;
         end
         default: begin
         end
      endcase
      slowClkSrcEn = 3'h0;
      if (slowClkRun) begin
         slowClkSrcEn = 3'h1 << slowClkSel;
      end
   end

   assign shutdown      = brownS;
   assign currentMode   = mode_r;
   assign wokeFromOff   = offWake_r;
   assign wakeGpioCause = cause_r;
   assign wakeByTimer   = causeTmr_r;
   assign debugAccessEn = dbg_r;
   assign rawReadAllow  = rawReadCmd && !lock_r;

endmodule // pmrw_power_ctrl

// ---- core/pmrw_watchdog.sv ----
// two-stage watchdog: warning pulse, then reset pulse
// assumes the kick comes from logic on the same clock
`timescale 1ns/1ns
`include "pmrw_consts.svh"

module pmrw_watchdog #(
   parameter int unsigned WARN_CYC  = `PMRW_WDT_WARN_CYC,
   parameter int unsigned RESET_CYC = `PMRW_WDT_RESET_CYC
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // control
   input  wire logic wdtEnable,
   input  wire logic wdtKick,
   // events
   output logic      wdtWarnIrq,
   output logic      wdtResetReq
);

   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic        warn_r;
   logic        warn_nxt;
   logic        rst_r;
   logic        rst_nxt;

   always_comb begin
      count_nxt = count_r;
      warn_nxt  = 1'b0;
      rst_nxt   = 1'b0;
      if (!wdtEnable || wdtKick) begin
         count_nxt = 32'h0;
      end else if (count_r == RESET_CYC - 1) begin
         rst_nxt   = 1'b1;
         count_nxt = 32'h0;
      end else begin
         count_nxt = count_r + 32'h1;
         warn_nxt  = (count_r == WARN_CYC - 1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count_r <= 32'h0;
         warn_r  <= 1'b0;
         rst_r   <= 1'b0;
      end else begin
         count_r <= count_nxt;
         warn_r  <= warn_nxt;
         rst_r   <= rst_nxt;
      end
   end

   assign wdtWarnIrq  = warn_r;
   assign wdtResetReq = rst_r;

endmodule // pmrw_watchdog

// ---- dv/pmrw_power_ctrl_checker.sv ----
// port checker for the power mode, reset and watchdog controller
// assumes it is bound to pmrw_power_ctrl and shares its clock
`timescale 1ns/1ns
module pmrw_power_ctrl_checker #(
   parameter int WARN_CYC  = 20,
   parameter int RESET_CYC = 40,
   parameter int STEP_CYC  = 16
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // watched inputs
   input wire logic       extResetN,
   input wire logic       brownoutLow,
   input wire logic       ldoStable,
   input wire logic [1:0] slowClkSel,
   input wire logic       cpuWfi,
   input wire logic       wakeTimerExpired,
   input wire logic       wdtEnable,
   input wire logic       wdtKick,
   input wire logic       lockoutFound,
   input wire logic       lockoutValid,
   // watched outputs
   input wire logic       buckEnable,
   input wire logic       radioLdoEnable,
   input wire logic       digitalLdoEnable,
   input wire logic       ldoLowVoltage,
   input wire logic       coreResetN,
   input wire logic       shutdown,
   input wire logic [2:0] slowClkSrcEn,
   input wire logic       slowClkRun,
   input wire logic       fastClkRun,
   input wire logic       fastClkSlow,
   input wire logic       radioPower,
   input wire logic       corePower,
   input wire logic       retentionPower,
   input wire logic [2:0] currentMode,
   input wire logic       debugAccessEn,
   input wire logic       rawReadAllow,
   input wire logic       wdtWarnIrq
);
   localparam int LDO_LO = STEP_CYC - 1;
   localparam int LDO_HI = STEP_CYC + 1;
   int quietCnt_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // unserviced running cycles
   always_ff @(posedge core_clk) begin
      if (!rstn || !wdtEnable || wdtKick || !coreResetN || currentMode != 3'h0) begin
         quietCnt_r <= 0;
      end else begin
         quietCnt_r <= quietCnt_r + 1;
      end
   end

   seq_order_a: assert property ((radioLdoEnable || digitalLdoEnable) |-> buckEnable)
      else $error("regulator on without buck");
   ldo_delay_a: assert property (disable iff (!rstn || !extResetN || brownoutLow)
      $rose(buckEnable) |-> !radioLdoEnable ##[LDO_LO:LDO_HI] radioLdoEnable)
      else $error("regulators not on one step after buck");
   core_release_a: assert property ($rose(coreResetN) |->
      $past(ldoStable) && digitalLdoEnable && radioLdoEnable)
      else $error("core released before rails stable");
   ext_reset_a: assert property (!extResetN |-> ##[1:4] !coreResetN)
      else $error("external reset ignored");
   brown_shut_a: assert property (brownoutLow |-> ##[1:4] shutdown)
      else $error("brownout without shutdown");
   debug_boot_a: assert property ($rose(coreResetN) |-> !debugAccessEn)
      else $error("debug open at power-up");
   lock_debug_a: assert property (lockoutValid && lockoutFound |=>
      !debugAccessEn && !rawReadAllow)
      else $error("lockout left access open");
   clk_select_a: assert property (slowClkRun && slowClkSel != 2'h3 &&
      $past(slowClkSel, 2) == slowClkSel |-> slowClkSrcEn == (3'h1 << slowClkSel))
      else $error("wrong slow clock source");
   idle_clock_a: assert property (currentMode == 3'h1 |-> fastClkRun && fastClkSlow)
      else $error("idle fast clock wrong");
   sleep_clock_a: assert property (currentMode == 3'h2 |->
      !fastClkRun && slowClkRun && ldoLowVoltage)
      else $error("sleep clocks or voltage wrong");
   retain_power_a: assert property (currentMode inside {3'h3, 3'h4} |->
      !radioPower && retentionPower && (currentMode != 3'h4 || !corePower))
      else $error("power-down sleep domains wrong");
   off_power_a: assert property (currentMode == 3'h5 |->
      !corePower && !radioPower && !slowClkRun)
      else $error("deep-off domains wrong");
   timer_wake_a: assert property (currentMode == 3'h2 && wakeTimerExpired |->
      ##[1:2] currentMode == 3'h0)
      else $error("timer did not wake sleep");
   mode_wfi_a: assert property (currentMode != $past(currentMode) &&
      currentMode != 3'h0 |-> $past(cpuWfi))
      else $error("mode entered without wait");
   wdt_warn_a: assert property (wdtWarnIrq |-> quietCnt_r >= WARN_CYC - 2)
      else $error("watchdog warning early");
   wdt_reset_a: assert property (quietCnt_r <= RESET_CYC + 4)
      else $error("watchdog reset missing");
endmodule // pmrw_power_ctrl_checker

bind pmrw_power_ctrl pmrw_power_ctrl_checker #(.WARN_CYC(WARN_CYC), .RESET_CYC(RESET_CYC),
   .STEP_CYC(STEP_CYC)) u_pmrw_checker (.*);

// ---- dv/pmrw_supply_model.sv ----
// supply rails and external reset source facing the controller pins
// assumes one clock shared with the controller
`timescale 1ns/1ns
module pmrw_supply_model #(
   parameter int HOLD_CYC = 4
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // rail enables and bench controls
   input  wire logic ldoOn,
   input  wire logic slowSupply,
   input  wire logic resetReq,
   // pins
   output logic      ldoStable,
   output logic      extResetN
);
   int settle_r;
   int hold_r;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hold_r   <= 0;
         settle_r <= 0;
      end else begin
         if (hold_r < HOLD_CYC) hold_r <= hold_r + 1;
         settle_r <= ldoOn ? settle_r + 1 : 0;
      end
   end
   // rails settle soon or late, drop at once when disabled
   assign ldoStable = ldoOn && (settle_r >= (slowSupply ? 12 : 2));
   // held low for HOLD_CYC cycles after bench reset, and on request
   assign extResetN = (hold_r >= HOLD_CYC) && !resetReq;
endmodule // pmrw_supply_model

// ---- dv/test_pmrw_power_ctrl.sv ----
// self-checking bench for the power mode, reset and watchdog controller
// assumes the bound checker and the supply model beside the design
`timescale 1ns/1ns
module test_pmrw_power_ctrl;
   localparam int WARN = 20;
   localparam int RST  = 40;
   localparam int STEP = 6;
   logic core_clk, rstn, extResetN, brownoutLow, ldoStable, modeReqValid, cpuWfi;
   logic wakeTimerExpired, wakeCauseClear, wdtEnable, wdtKick, lockoutFound, lockoutValid;
   logic debugEnableReq, rawReadCmd, buckEnable, radioLdoEnable, digitalLdoEnable;
   logic ldoLowVoltage, coreResetN, shutdown, slowClkRun, fastClkRun, fastClkSlow;
   logic periphClkGate, radioPower, corePower, retentionPower, wokeFromOff, wakeByTimer;
   logic debugAccessEn, rawReadAllow, wdtWarnIrq, slowSupply, resetReq;
   logic [7:0] gpioWake, gpioWakeEnable, wakeGpioCause;
   logic [2:0] modeReq, slowClkSrcEn, currentMode;
   logic [1:0] slowClkSel;
   int         num_errors, n_tests, seed, n, b, warnSeen;

   pmrw_power_ctrl #(.WARN_CYC(WARN), .RESET_CYC(RST), .STEP_CYC(STEP)) u_pmrw_power_ctrl (.*);
   pmrw_supply_model u_pmrw_supply_model (.core_clk(core_clk), .rstn(rstn),
      .ldoOn(radioLdoEnable && digitalLdoEnable), .slowSupply(slowSupply),
      .resetReq(resetReq), .ldoStable(ldoStable), .extResetN(extResetN));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (wdtWarnIrq === 1'b1) warnSeen++;

   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   task automatic waitRun();
      n = 0;
      while (coreResetN !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      chk(coreResetN, 1);
   endtask
   task automatic enter(input logic [2:0] m);
      @(posedge core_clk);
      modeReqValid <= 1'b1;
      modeReq      <= m;
      @(posedge core_clk);
      modeReqValid <= 1'b0;
      cyc(2);
      chk(currentMode, 0);
      @(posedge core_clk);
      cpuWfi <= 1'b1;
      cyc(3);
      chk(currentMode, m);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      print_verdict();
   end

   initial begin
      seed = 32'h8322e714;
      {num_errors, n_tests, warnSeen} = '0;
      {rstn, brownoutLow, modeReqValid, cpuWfi, wakeTimerExpired, wakeCauseClear} = '0;
      {wdtEnable, wdtKick, lockoutFound, lockoutValid, debugEnableReq, rawReadCmd} = '0;
      {slowSupply, resetReq, gpioWake, gpioWakeEnable, modeReq, slowClkSel} = '0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      n = 0;
      do begin
         cyc(1);
         n = buckEnable ? n + 1 : 0;
      end while (radioLdoEnable !== 1'b1 && n < 100);
      chk(n, STEP + 1);
      chk(digitalLdoEnable, 1);
      chk(coreResetN, 0);
      waitRun();
      chk(debugAccessEn, 0);
      for (int s = 0; s < 3; s++) begin
         @(posedge core_clk);
         slowClkSel <= s[1:0];
         cyc(3);
         chk(slowClkSrcEn, 3'h1 << s);
      end
      for (int m = 1; m < 5; m++) begin
         b = $random(seed) & 7;
         @(posedge core_clk);
         gpioWakeEnable <= 8'h1 << b;
         enter(m[2:0]);
         chk(fastClkRun, m == 1);
         chk(periphClkGate, m != 1);
         @(posedge core_clk);
         gpioWake <= 8'h1 << ((b + 1) % 8);
         cyc(5);
         chk(currentMode, m);
         @(posedge core_clk);
         if (m == 1) cpuWfi <= 1'b0;
         else if (m == 2 || ($random(seed) & 1)) wakeTimerExpired <= 1'b1;
         else gpioWake <= 8'h1 << b;
         cyc(5);
         chk(currentMode, 0);
         @(posedge core_clk);
         {gpioWake, wakeTimerExpired, cpuWfi} <= '0;
      end
      // deep-off woken by gpio, then by the timer
      for (int k = 0; k < 2; k++) begin
         b = $random(seed) & 7;
         @(posedge core_clk);
         gpioWakeEnable <= 8'h1 << b;
         slowSupply     <= 1'b1;
         enter(3'h5);
         chk(corePower, 0);
         chk(slowClkRun, 0);
         @(posedge core_clk);
         if (k == 0) gpioWake <= 8'h1 << b;
         else wakeTimerExpired <= 1'b1;
         cpuWfi <= 1'b0;
         cyc(4);
         @(posedge core_clk);
         {gpioWake, wakeTimerExpired} <= '0;
         waitRun();
         chk(wokeFromOff, 1);
         chk(wakeGpioCause, k ? 8'h0 : 8'h1 << b);
         chk(wakeByTimer, k);
         @(posedge core_clk);
         wakeCauseClear <= 1'b1;
         @(posedge core_clk);
         wakeCauseClear <= 1'b0;
         cyc(2);
         chk(wokeFromOff, 0);
         chk(wakeByTimer, 0);
      end
      @(posedge core_clk);
      debugEnableReq <= 1'b1;
      rawReadCmd     <= 1'b1;
      @(posedge core_clk);
      debugEnableReq <= 1'b0;
      cyc(2);
      chk(debugAccessEn, 1);
      chk(rawReadAllow, 1);
      @(posedge core_clk);
      {lockoutValid, lockoutFound} <= 2'h3;
      @(posedge core_clk);
      lockoutValid   <= 1'b0;
      debugEnableReq <= 1'b1;
      @(posedge core_clk);
      debugEnableReq <= 1'b0;
      cyc(2);
      chk(debugAccessEn, 0);
      chk(rawReadAllow, 0);
      @(posedge core_clk);
      wdtEnable <= 1'b1;
      repeat (6) begin
         repeat (($random(seed) & 7) + 8) @(posedge core_clk);
         wdtKick <= 1'b1;
         @(posedge core_clk);
         wdtKick <= 1'b0;
      end
      chk(warnSeen, 0);
      n = 0;
      while (wdtWarnIrq !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk(n >= WARN - 1 && n <= WARN + 2, 1);
      while (coreResetN === 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk(n >= RST - 1 && n <= RST + 5, 1);
      @(posedge core_clk);
      wdtEnable <= 1'b0;
      waitRun();
      chk(warnSeen, 1);
      @(posedge core_clk);
      resetReq <= 1'b1;
      cyc(4);
      chk(coreResetN, 0);
      @(posedge core_clk);
      resetReq <= 1'b0;
      waitRun();
      @(posedge core_clk);
      brownoutLow <= 1'b1;
      cyc(4);
      chk(shutdown, 1);
      @(posedge core_clk);
      brownoutLow <= 1'b0;
      waitRun();
      print_verdict();
   end
endmodule // test_pmrw_power_ctrl
